// *** hw/ssp_pkg.sv ***
/*
 * shared constants for the synchronous pipelined sram pin interface.
 * assumes a single 50 MHz system clock and an Avalon-MM register master.
 */
package ssp_pkg;
	localparam int          SSP_CLK_HZ       = 50_000_000;
	localparam int          SSP_SLEEP_CYC    = 2;
	localparam int          SSP_BURST_LEN    = 4;
	localparam int          SSP_BYTES        = 4;
	localparam int          SSP_DATA_W       = 32;
	localparam int          SSP_ADDR_W       = 8;
	// register word offsets (byte addresses)
	localparam logic [3:0]  SSP_REG_CTRL     = 4'h0;
	localparam logic [3:0]  SSP_REG_STATUS   = 4'h4;
	localparam logic [3:0]  SSP_REG_ID       = 4'h8;
	// control bit positions
	localparam int          SSP_CTRL_SLEEP   = 0;
	localparam int          SSP_CTRL_MODEOVR = 1;
	localparam int          SSP_CTRL_MODEVAL = 2;
	localparam logic [31:0] SSP_CTRL_RST     = 32'h0000_0000;
	// arbitrary neutral identity value
	localparam logic [31:0] SSP_ID_VALUE     = 32'h0000_5a5a;
	typedef enum logic [2:0] {
		SSP_AWAKE    = 3'b001,
		SSP_ENTERING = 3'b010,
		SSP_ASLEEP   = 3'b100
	} ssp_sleep_e;
endpackage

// *** hw/ssp_sram.sv ***
/*
 * pin-level model of a synchronous pipelined burst sram with shared data
 * and parity lines, burst counter, sleep control and test port sampling.
 * assumes all pins synchronous to i_mclk; the test clock is an ordinary
 * input whose edges are detected in the i_mclk domain.
 * limitation: test clock edges are seen only at the next system clock edge, so the test
 * clock must stay well below the system clock.
 * limitation: an access still in flight when sleep starts is held and completes after wake.
 * open strap and sleep pins arrive as explicit flags from the pad ring.
 */
// Function
// - act only on edges with qualifier low
// - qualifier high freezes the access, burst and read output state
// - qualifier high stretches, does not deselect
// - write data captured on rising edge
// - read data registered from previous address
// - drive data only when output enable low
// - output enable high tristates data lines
// - tristate on write, first cycle, deselected
// - parity lines like data, lane gated
// - strap high interleaved, low linear
// - open strap reads as interleaved
// - test output changes on falling edge
// - test data sampled on rising edge
// - mode select sampled on rising edge
// - sleep high enters low power, keeps data
// - open sleep input reads low
// - sleep entry and exit take two cycles
// - burst of four, wrapping, strap order
module ssp_sram #(
	parameter int DEPTH = 256
) (
	// clock and reset
	input  wire logic                                  i_mclk,
	input  wire logic                                  i_arst_n,
	// sram control pins
	input  wire logic                                  i_clock_qualifier_n,
	input  wire logic                                  i_chip_select_1_n,
	input  wire logic                                  i_chip_select_2,
	input  wire logic                                  i_chip_select_3_n,
	input  wire logic                                  i_advance_or_load,
	input  wire logic                                  i_write_n,
	input  wire logic [ssp_pkg::SSP_BYTES-1:0]         i_byte_write_select_n,
	input  wire logic [ssp_pkg::SSP_ADDR_W-1:0]        i_addr,
	input  wire logic                                  i_output_enable_n,
	input  wire logic                                  i_burst_order,
	input  wire logic                                  i_burst_order_open,
	input  wire logic                                  i_sleep_request,
	input  wire logic                                  i_sleep_open,
	// data and parity lines
	input  wire logic [ssp_pkg::SSP_DATA_W-1:0]        i_dq,
	output logic      [ssp_pkg::SSP_DATA_W-1:0]        o_dq,
	output logic      [ssp_pkg::SSP_DATA_W-1:0]        o_dq_oe,
	input  wire logic [ssp_pkg::SSP_BYTES-1:0]         i_parity_lines,
	output logic      [ssp_pkg::SSP_BYTES-1:0]         o_parity_lines,
	output logic      [ssp_pkg::SSP_BYTES-1:0]         o_parity_lines_oe,
	// test port
	input  wire logic                                  i_test_clk,
	input  wire logic                                  i_test_mode,
	input  wire logic                                  i_test_din,
	output logic                                       o_test_dout,
	// status
	output logic                                       o_asleep,
	// avalon-mm slave
	input  wire logic [3:0]                            i_avs_address,
	input  wire logic                                  i_avs_read,
	input  wire logic                                  i_avs_write,
	input  wire logic [31:0]                           i_avs_writedata,
	output logic      [31:0]                           o_avs_readdata,
	output logic                                       o_avs_waitrequest
);
	import ssp_pkg::*;

	localparam int BW = SSP_DATA_W / SSP_BYTES;

	wire  [SSP_DATA_W-1:0]  rd_dat;
	wire  [SSP_BYTES-1:0]   rd_par;
	logic [SSP_BYTES-1:0]   wr_en;
	logic                   tck_rise;
	logic                   tck_fall;
	logic                   acc_go;
	logic [31:0]            ctrl_r;
	ssp_sleep_e             slp_r;
	logic [1:0]             slp_cnt_r;
	logic                   sleep_in;
	logic                   order_il;
	logic                   clk_ok;
	logic [SSP_ADDR_W-1:0]  base_r;
	logic [1:0]             bcnt_r;
	logic [SSP_ADDR_W-1:0]  cur_addr;
	logic                   sel_r;
	logic                   wr_r;
	logic                   act_r;
	logic                   wr_data_r;
	logic                   rd_data_r;
	logic                   emerge_r;
	logic [SSP_ADDR_W-1:0]  wr_addr_r;
	logic [SSP_DATA_W-1:0]  dout_r;
	logic [SSP_BYTES-1:0]   pout_r;
	logic                   drive;
	logic                   cs_all;
	logic                   tck_d_r;
	logic [7:0]             shift_r;
	logic                   ack_r;

	// open pins resolve through their internal pulls
	assign sleep_in = i_sleep_open ? 1'b0 : i_sleep_request;
	assign order_il = ctrl_r[SSP_CTRL_MODEOVR] ? ctrl_r[SSP_CTRL_MODEVAL] :
	                  (i_burst_order_open ? 1'b1 : i_burst_order);
	// sleeping core ignores the clock; pending accesses are held until wake
	assign clk_ok   = !i_clock_qualifier_n && (slp_r == SSP_AWAKE);
	assign cs_all   = !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
	assign cur_addr = {base_r[SSP_ADDR_W-1:2],
	                   order_il ? (base_r[1:0] ^ bcnt_r) : (base_r[1:0] + bcnt_r)};

	// sleep sequencer: two cycles each way
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			slp_r     <= SSP_AWAKE;
			slp_cnt_r <= 2'h0;
		end else begin
			case (slp_r)
				SSP_AWAKE: begin
					if (sleep_in || ctrl_r[SSP_CTRL_SLEEP]) begin
						slp_r     <= SSP_ENTERING;
						slp_cnt_r <= 2'h1;
					end
				end
				SSP_ENTERING: begin
					if (slp_cnt_r == 2'(SSP_SLEEP_CYC - 1))
						slp_r <= SSP_ASLEEP;
					else
						slp_cnt_r <= slp_cnt_r + 2'h1;
				end
				SSP_ASLEEP: begin
					if (!(sleep_in || ctrl_r[SSP_CTRL_SLEEP])) begin
						slp_cnt_r <= slp_cnt_r - 2'h1;
						if (slp_cnt_r == 2'h0)
							slp_r <= SSP_AWAKE;
					end else
						slp_cnt_r <= 2'(SSP_SLEEP_CYC - 1);
				end
				default: slp_r <= SSP_AWAKE;
			endcase
		end
	end
	assign o_asleep = (slp_r == SSP_ASLEEP);

	// burst address: loaded on a qualified load, stepped on a qualified advance
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			base_r <= '0;
			bcnt_r <= 2'h0;
		end else if (clk_ok) begin
			if (!i_advance_or_load) begin
				base_r <= i_addr;
				bcnt_r <= 2'h0;
			end else begin
				bcnt_r <= bcnt_r + 2'h1;
			end
		end
	end

	// access type and select, latched at load and kept through the burst
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_r    <= 1'b0;
			wr_r     <= 1'b0;
			act_r    <= 1'b0;
			emerge_r <= 1'b0;
		end else if (clk_ok) begin
			if (!i_advance_or_load) begin
				sel_r    <= cs_all;
				wr_r     <= !i_write_n;
				act_r    <= cs_all;
				emerge_r <= cs_all && !sel_r;
			end else begin
				act_r    <= sel_r;
				emerge_r <= 1'b0;
			end
		end
	end

	// data phase flags trail the access by one qualified edge
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_data_r <= 1'b0;
			rd_data_r <= 1'b0;
			wr_addr_r <= '0;
		end else if (clk_ok) begin
			wr_data_r <= act_r && wr_r;
			rd_data_r <= act_r && !wr_r;
			wr_addr_r <= cur_addr;
		end
	end

	// per-lane write strobes
	assign wr_en = {SSP_BYTES{clk_ok && wr_data_r}} & ~i_byte_write_select_n;
	// drivers: lanes share one enable, so no lane can fight the controller alone
	assign drive = !i_output_enable_n && rd_data_r && !emerge_r;

	// storage: one bank per byte lane, so lanes write independently
	generate
		for (genvar g = 0; g < SSP_BYTES; g++) begin : g_lane
			logic [BW-1:0] dat_r [DEPTH];
			logic          par_r [DEPTH];
			always_ff @(posedge i_mclk) begin
				if (wr_en[g]) begin
					dat_r[wr_addr_r] <= i_dq[g*BW +: BW];
					par_r[wr_addr_r] <= i_parity_lines[g];
				end
			end
			assign rd_dat[g*BW +: BW]   = dat_r[cur_addr];
			assign rd_par[g]            = par_r[cur_addr];
			assign o_dq_oe[g*BW +: BW]  = {BW{drive}};
			assign o_parity_lines_oe[g] = drive;
		end
	endgenerate

	// read output register; a stall or sleep leaves it untouched
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dout_r <= '0;
			pout_r <= '0;
		end else if (clk_ok && act_r && !wr_r) begin
			dout_r <= rd_dat;
			pout_r <= rd_par;
		end
	end
	assign o_dq           = dout_r;
	assign o_parity_lines = pout_r;

	// test clock edges as seen in the system clock domain, at the first edge that samples the new level
	assign tck_rise = i_test_clk && !tck_d_r;
	assign tck_fall = !i_test_clk && tck_d_r;
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= i_test_clk;
		end
	end

	// shift register: mode high clears, otherwise data enters at the top
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift_r <= 8'h00;
		end else if (tck_rise) begin
			if (i_test_mode)
				shift_r <= 8'h00;
			else
				shift_r <= {i_test_din, shift_r[7:1]};
		end
	end

	// serial out moves on the fall only, so the far side can sample on the rise
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_test_dout <= 1'b0;
		end else if (tck_fall) begin
			o_test_dout <= shift_r[0];
		end
	end

	// avalon-mm slave: one wait cycle per access
	assign acc_go = (i_avs_read || i_avs_write) && !ack_r;
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc_go;
		end
	end

	// control write lands on the edge after the wait ends, when waitrequest is low, as the master expects
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_r <= SSP_CTRL_RST;
		end else if (i_avs_write && ack_r && i_avs_address == SSP_REG_CTRL) begin
			ctrl_r <= i_avs_writedata & 32'h0000_0007;
		end
	end

	// read data registered on the first edge, standing when the wait ends
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (acc_go) begin
			case (i_avs_address)
				SSP_REG_CTRL:   o_avs_readdata <= ctrl_r;
				SSP_REG_STATUS: o_avs_readdata <= {28'h0, order_il, sel_r,
				                                   o_asleep, slp_r != SSP_AWAKE};
				SSP_REG_ID:     o_avs_readdata <= SSP_ID_VALUE;
				default:        o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end
	assign o_avs_waitrequest = acc_go;
endmodule

// *** dv/ssp_ctrl_model.sv ***
/* controller side of the shared data and parity lines.
   assumes device data and enables arrive on separate ports. */
module ssp_ctrl_model (
	input  wire logic        i_mclk,
	input  wire logic        i_drv,
	input  wire logic [35:0] i_drv_d,
	input  wire logic [35:0] i_dev_d,
	input  wire logic [35:0] i_dev_oe,
	output logic      [35:0] o_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [35:0] last_r = '0;
	// no pull on these lines: released bits toggle so a stale value never passes
	always_comb
		for (int i = 0; i < 36; i++)
			o_bus[i] = i_dev_oe[i] ? (i_drv ? 1'bx : i_dev_d[i])
				: (i_drv ? i_drv_d[i] : ~last_r[i]);
	always_ff @(posedge i_mclk)
		last_r <= o_bus;
endmodule

// *** dv/ssp_sram_assertions.sv ***
/* checker bound to ssp_sram.
   assumes one clock domain and port names as on the design. */
module ssp_sram_assertions (
	input wire logic        i_mclk, i_arst_n, i_clock_qualifier_n, i_advance_or_load, i_write_n,
	input wire logic        i_chip_select_1_n, i_chip_select_2, i_chip_select_3_n, i_sleep_open,
	input wire logic        i_output_enable_n, i_sleep_request, i_test_clk, i_avs_read,
	input wire logic        i_avs_write, o_avs_waitrequest, o_asleep, o_test_dout,
	input wire logic [31:0] o_dq, o_dq_oe,
	input wire logic [3:0]  o_parity_lines_oe
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	wire sel = !i_clock_qualifier_n && !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
	a_oe_off_tristate:
		assert property (i_output_enable_n |-> o_dq_oe == '0) else $error("drive with oe high");
	a_parity_lane_oe:
		assert property (o_parity_lines_oe == {4{o_dq_oe[0]}}) else $error("parity oe differs");
	a_stall_holds_out:
		assert property (i_clock_qualifier_n |=> $stable(o_dq)) else $error("output moved");
	a_sleep_two_edges:
		assert property ($rose(i_sleep_request) && !i_sleep_open ##1 i_sleep_request
			|-> !o_asleep ##1 o_asleep) else $error("sleep entry timing");
	a_bus_one_wait:
		assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest
			##1 !o_avs_waitrequest) else $error("waitrequest timing");
	a_write_phase_off:
		assert property (sel && !i_advance_or_load && !i_write_n ##1 !i_clock_qualifier_n
			|=> o_dq_oe == '0) else $error("drive in write data phase");
	a_deselect_off:
		assert property ((!i_clock_qualifier_n && !sel && !i_advance_or_load) [*2]
			|=> o_dq_oe == '0) else $error("drive while deselected");
	a_test_out_fall:
		assert property ($changed(o_test_dout) |-> !$past(i_test_clk) && $past(i_test_clk, 2))
			else $error("test out");
endmodule
bind ssp_sram ssp_sram_assertions u_chk (.*);

// *** dv/ssp_sram_tb_top.sv ***
/* self-checking bench for ssp_sram: pin traffic through the controller
   model, registers over avalon-mm. assumes a 50 MHz clock. */
`define CHK(n, s, e) begin total_checks++; if ((s) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module ssp_sram_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ssp_pkg::*;
	logic i_mclk = 0, i_arst_n = 0, i_clock_qualifier_n = 0, i_advance_or_load = 0, drv = 0;
	logic i_chip_select_1_n = 1, i_chip_select_2 = 0, i_chip_select_3_n = 1, i_write_n = 1;
	logic i_burst_order = 1, i_burst_order_open = 0, i_sleep_request = 0, i_sleep_open = 0;
	logic i_test_clk = 0, i_test_mode = 0, i_test_din = 0, i_avs_read = 0, i_avs_write = 0;
	logic i_output_enable_n = 1, o_test_dout, o_asleep, o_avs_waitrequest;
	logic [3:0]  i_byte_write_select_n = '0, i_avs_address = '0, o_parity_lines, o_parity_lines_oe;
	logic [7:0]  i_addr = '0;
	logic [31:0] i_avs_writedata = '0, o_avs_readdata, o_dq, o_dq_oe, rd;
	logic [35:0] drv_d = '0, bus;
	logic [35:0] dat [4] = '{36'ha_1111_1111, 36'h5_2222_2222, 36'hc_3333_3333, 36'h3_4444_4444};
	wire  [31:0] i_dq = bus[31:0];
	wire  [3:0]  i_parity_lines = bus[35:32];
	int errors = 0, total_checks = 0;
	logic [15:0] p = 16'h5ac3;
	ssp_ctrl_model ctl (.i_mclk(i_mclk), .i_drv(drv), .i_drv_d(drv_d),
		.i_dev_d({o_parity_lines, o_dq}), .i_dev_oe({o_parity_lines_oe, o_dq_oe}), .o_bus(bus));
	ssp_sram uut (.*);
	always #10 i_mclk = ~i_mclk;
	// c = {drive data, qualifier_n, select, advance, write_n}
	task automatic op(input logic [4:0] c, input logic [7:0] a, input logic [35:0] d, int k);
		@(posedge i_mclk);
		{drv, i_clock_qualifier_n, i_chip_select_2, i_advance_or_load, i_write_n} <= c;
		{i_chip_select_1_n, i_chip_select_3_n} <= {2{!c[2]}};
		i_addr <= a;
		drv_d <= d;
		@(negedge i_mclk);
		if (k == 1) `CHK("bus", bus, d)
		if (k == 2) `CHK("oe", {o_parity_lines_oe, o_dq_oe}, 36'h0)
	endtask
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd);
		@(posedge i_mclk);
		{i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, !w, a, wd};
		do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		{i_avs_write, i_avs_read} <= 2'b00;
	endtask
	task automatic slp(input logic [1:0] v, input logic e);
		@(posedge i_mclk);
		{i_sleep_open, i_sleep_request} <= v;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
		`CHK("asleep", o_asleep, e)
	endtask
	// one full test clock period, then a look at the serial output
	task automatic tck(input logic d, input logic m, input logic e);
		@(posedge i_mclk) {i_test_clk, i_test_din, i_test_mode} <= {1'b1, d, m};
		repeat (3) @(posedge i_mclk);
		i_test_clk <= 1'b0;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
		`CHK("test_dout", o_test_dout, e)
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_mclk);
		i_arst_n <= 1;
		av(0, SSP_REG_CTRL, 0);
		`CHK("ctrl", rd, SSP_CTRL_RST)
		av(1, SSP_REG_CTRL, 32'h6);
		av(0, SSP_REG_CTRL, 0);
		`CHK("ctrl", rd, 32'h6)
		av(1, SSP_REG_CTRL, 0);
		av(1, SSP_REG_CTRL, 32'h2);
		av(0, SSP_REG_STATUS, 0);
		`CHK("override", rd[3], 1'b0)
		av(1, SSP_REG_CTRL, 32'h1);
		av(0, SSP_REG_STATUS, 0);
		`CHK("sleeping", rd[1:0], 2'b01)
		av(1, SSP_REG_CTRL, 0);
		av(0, SSP_REG_ID, 0);
		`CHK("id", rd, SSP_ID_VALUE)
		av(0, 4'hc, 0);
		`CHK("unmapped", rd, 32'h0)
		i_output_enable_n <= 0;
		op(5'b00100, 8'h11, 0, 0);
		op(5'b00110, 0, 0, 0);
		for (int i = 0; i < 4; i++)
			op(i < 2 ? 5'b10110 : 5'b10001, 0, dat[i], 0);
		op(5'b00001, 0, 0, 0);
		slp(2'b01, 1'b1);
		slp(2'b00, 1'b0);
		slp(2'b11, 1'b0);
		slp(2'b00, 1'b0);
		@(posedge i_mclk) {i_burst_order, i_burst_order_open} <= 2'b01;
		av(0, SSP_REG_STATUS, 0);
		`CHK("interleaved", rd[3], 1'b1)
		@(posedge i_mclk) i_burst_order_open <= 0;
		av(0, SSP_REG_STATUS, 0);
		`CHK("interleaved", rd[3], 1'b0)
		// linear read from 0x12 after interleaved write from 0x11, with one stall
		op(5'b00101, 8'h12, 0, 0);
		op(5'b00111, 0, 0, 0);
		op(5'b00111, 0, dat[3], 1);
		op(5'b01111, 0, dat[2], 1);
		op(5'b00111, 0, dat[2], 1);
		op(5'b00001, 0, dat[1], 1);
		op(5'b00001, 0, dat[0], 1);
		op(5'b00001, 0, 0, 2);
		for (int k = 1; k <= 16; k++)
			tck(p[k-1], 1'b0, k >= 8 ? p[k-8] : 1'b0);
		tck(1'b1, 1'b1, 1'b0);
		test_done;
	end
	initial begin
		repeat (3000) @(posedge i_mclk);
		errors++;
		test_done;
	end
endmodule
